// ==== rtl/lcdrp_defs.svh ====
/*
 * Offsets, field positions and reset values of the display access port.
 * Assumes inclusion by bare name from rtl files; definitions only.
 */
`ifndef LCDRP_DEFS_SVH
`define LCDRP_DEFS_SVH

`define LCDRP_PORT_OFFSET 16'h0010
`define LCDRP_WIN_AW 16
`define LCDRP_REG_W 16
`define LCDRP_BIT_FIRST 0
`define LCDRP_BIT_SECOND 1
`define LCDRP_BIT_CMDDATA 6
`define LCDRP_BIT_DIR 7
`define LCDRP_DATA_LSB 8
`define LCDRP_DATA_MSB 15
`define LCDRP_LOW_MASK 8'hc3
`define LCDRP_RESET_VAL 16'h0000

`endif

// ==== rtl/lcdrp_pkg.sv ====
/*
 * Types shared by the display access port.
 * Assumes the constants header is compiled alongside.
 */
package lcdrp_pkg;
	typedef logic [15:0] lcdrp_word_t;
	typedef logic [7:0] lcdrp_byte_t;
endpackage

// ==== rtl/lcdrp_port.sv ====
/*
 * Display access port: one 16-bit register on the processor bus, held
 * onto a slow character display module.
 * Assumes the bus presents a chip select, a byte offset inside the
 * chip-select window, a write strobe and a read strobe, each valid for
 * one cycle per access; the bus master sequences the module handshake.
 */
// Behaviour
// - Single 16-bit register; every access completes in one bus cycle.
// - Last written control stays driven onto the module; data is driven only while bit 7 is 0.
// - Bit 0 drives first module-half select, active high.
// - Bit 1 drives second module-half select; bits 2 to 5 unused.
// - Bit 6 drives command/data select: 0 command, 1 display data.
// - Bit 7 drives direction: 0 write to module, 1 read.
// - Bits 8..15 carry module bits 7..0; out on write, in on read.
// - Decoded at offset 0x0010 in chip select window, map enable set.
`timescale 1ns/10ps
`include "lcdrp_defs.svh"
module lcdrp_port (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Processor bus
	input wire logic display_chip_select_i,
	input wire logic map_enable_i,
	input wire logic [15:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o,
	output logic ack_o,
	// Display module
	output logic first_half_enable_o,
	output logic second_half_enable_o,
	output logic cmd_data_select_o,
	output logic dir_read_o,
	input wire logic [7:0] mod_data_i,
	output logic [7:0] mod_data_o,
	output logic [7:0] mod_data_oe_o
);
	// ********************************
	// Decode and helpers
	// ********************************
	function automatic lcdrp_pkg::lcdrp_byte_t bit_rev(
		input lcdrp_pkg::lcdrp_byte_t b);
		lcdrp_pkg::lcdrp_byte_t r;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7 - i];
		end
		return r;
	endfunction

	logic hit;
	lcdrp_pkg::lcdrp_byte_t pins_sync;

	// Map enable is a board strap, not an on-chip signal, so it is synced
	logic [1:0] men_q;
	logic [1:0] men_d;

	lcdrp_sync u_sync (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.async_i(mod_data_i),
		.sync_o(pins_sync)
	);

	always_comb begin
		men_d = {men_q[0], map_enable_i};
		if (!rstn_i) begin
			men_d = 2'b00;
		end
	end

	always_ff @(posedge mclk_i) begin
		men_q <= men_d;
	end

	assign hit = display_chip_select_i && men_q[1] &&
		(addr_i == `LCDRP_PORT_OFFSET);

	// ********************************
	// Access register
	// ********************************
	lcdrp_pkg::lcdrp_word_t word_q;
	lcdrp_pkg::lcdrp_word_t word_d;
	lcdrp_pkg::lcdrp_word_t rdata_q;
	lcdrp_pkg::lcdrp_word_t rdata_d;
	logic ack_q;
	logic ack_d;

	always_comb begin
		word_d = word_q;
		rdata_d = rdata_q;
		ack_d = 1'b0;
		if (hit && wr_i) begin
			// Unused bits 2..5 are not stored and read back zero
			word_d = wdata_i & 16'hffc3;
			ack_d = 1'b1;
		end else if (hit && rd_i) begin
			// Byte comes from module pins, low half from stored bits
			rdata_d = {bit_rev(pins_sync),
				word_q[7:0] & `LCDRP_LOW_MASK};
			ack_d = 1'b1;
		end
		if (!rstn_i) begin
			word_d = `LCDRP_RESET_VAL;
			rdata_d = 16'h0000;
			ack_d = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		word_q <= word_d;
		rdata_q <= rdata_d;
		ack_q <= ack_d;
	end

	// ********************************
	// Module pins
	// ********************************
	// Selects follow the register directly; the master orders the
	// writes so data and direction settle before a half is selected.
	assign first_half_enable_o = word_q[`LCDRP_BIT_FIRST];
	assign second_half_enable_o = word_q[`LCDRP_BIT_SECOND];
	assign cmd_data_select_o = word_q[`LCDRP_BIT_CMDDATA];
	assign dir_read_o = word_q[`LCDRP_BIT_DIR];
	assign mod_data_o =
		bit_rev(word_q[`LCDRP_DATA_MSB:`LCDRP_DATA_LSB]);
	assign mod_data_oe_o = {8{~word_q[`LCDRP_BIT_DIR]}};
	assign rdata_o = rdata_q;
	assign ack_o = ack_q;
endmodule

// ==== rtl/lcdrp_sync.sv ====
/*
 * Two-flop synchroniser for the display module data pins.
 * Assumes a single clock domain on the consumer side.
 */
`timescale 1ns/10ps
module lcdrp_sync (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Data
	input wire logic [7:0] async_i,
	output logic [7:0] sync_o
);
	logic [7:0] meta_q;
	logic [7:0] meta_d;
	logic [7:0] sync_q;
	logic [7:0] sync_d;

	always_comb begin
		meta_d = async_i;
		sync_d = meta_q;
		if (!rstn_i) begin
			meta_d = 8'h00;
			sync_d = 8'h00;
		end
	end

	always_ff @(posedge mclk_i) begin
		meta_q <= meta_d;
		sync_q <= sync_d;
	end

	assign sync_o = sync_q;
endmodule

// ==== verif/lcdrp_display.sv ====
/* Display module model: returns its byte while selected for reading.
   Assumes selects and direction come straight from the port. */
`timescale 1ns/10ps
module lcdrp_display (input wire logic mclk_i, sel_i, dir_i,
	input wire logic [7:0] byte_i, output logic [7:0] bus_o);
	initial bus_o = 8'h00;
	// Released bus toggles so stale data cannot pass
	always @(posedge mclk_i) begin
		bus_o <= (sel_i && dir_i) ? byte_i : ~bus_o;
	end
endmodule

// ==== verif/lcdrp_properties.sv ====
/* Port checker for the display access port.
   Assumes a bind onto lcdrp_port and a held map enable. */
`timescale 1ns/10ps
module lcdrp_chk (input wire logic mclk_i, rstn_i, display_chip_select_i,
	map_enable_i, wr_i, rd_i, ack_o, first_half_enable_o,
	second_half_enable_o, cmd_data_select_o, dir_read_o,
	input wire logic [15:0] addr_i, wdata_i, rdata_o,
	input wire logic [7:0] mod_data_o, mod_data_oe_o);
	logic [1:0] me_q;
	wire logic hit = display_chip_select_i && addr_i == 16'h0010 && me_q[1];
	wire logic [11:0] pins = {first_half_enable_o, second_half_enable_o,
		cmd_data_select_o, dir_read_o, mod_data_o};
	// Mirrors the two-flop map enable sync
	always_ff @(posedge mclk_i) begin
		me_q <= rstn_i ? {me_q[0], map_enable_i} : 2'h0;
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	a_write_ack: assert property (hit && wr_i |=> ack_o)
		else $error("write not acknowledged");
	a_no_stray: assert property (!(hit && (wr_i || rd_i)) |=> !ack_o)
		else $error("ack without decoded access");
	a_half_sel: assert property (hit && wr_i |=> pins[11:10] ==
		{$past(wdata_i[0]), $past(wdata_i[1])}) else $error("half select");
	a_cmd_dir: assert property (hit && wr_i |=> pins[9:8] ==
		{$past(wdata_i[6]), $past(wdata_i[7])}) else $error("cmd or dir");
	a_byte_order: assert property (hit && wr_i |=> mod_data_o[7] ==
		$past(wdata_i[8]) && mod_data_o[0] == $past(wdata_i[15]))
		else $error("data byte order");
	a_pins_hold: assert property (!(hit && wr_i) |=> $stable(pins))
		else $error("pins moved without write");
	a_oe_dir: assert property (mod_data_oe_o == {8{!dir_read_o}})
		else $error("output enable");
	a_read_low: assert property (hit && rd_i && !wr_i |=>
		rdata_o[7:0] == {pins[8], pins[9], 4'h0, pins[10], pins[11]})
		else $error("read low bits");
endmodule
bind lcdrp_port lcdrp_chk u_chk (.*);

// ==== verif/tb.sv ====
/* Self-checking bench of the display access port.
   Assumes the bus master sequence is driven by the tasks here. */
`timescale 1ns/10ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
	err_count++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb;
	logic mclk_i = 0, rstn = 0, cs = 0, me = 1, wr = 0, rd = 0, ack;
	logic fh, sh, cds, dr;
	logic [15:0] addr = 0, wdata = 0, rdata;
	logic [7:0] mdi, mdo, oe;
	int err_count = 0, total_checks = 0;
	logic [15:0] tw [6] = '{16'ha540, 16'ha541, 16'ha540, 16'h5a00,
		16'h5a3e, 16'h5a00};
	wire logic [19:0] pins = {fh, sh, cds, dr, mdo, oe};
	always #4 mclk_i = ~mclk_i;
	lcdrp_port dut (.mclk_i, .rstn_i(rstn), .display_chip_select_i(cs),
		.map_enable_i(me), .addr_i(addr), .wr_i(wr), .rd_i(rd),
		.wdata_i(wdata), .rdata_o(rdata), .ack_o(ack),
		.first_half_enable_o(fh), .second_half_enable_o(sh),
		.cmd_data_select_o(cds), .dir_read_o(dr), .mod_data_i(mdi),
		.mod_data_o(mdo), .mod_data_oe_o(oe));
	lcdrp_display u_disp (.mclk_i, .sel_i(fh | sh), .dir_i(dr),
		.byte_i(8'h1d), .bus_o(mdi));
	function automatic logic [19:0] ex(input logic [15:0] v);
		return {v[0], v[1], v[6], v[7], v[8], v[9], v[10], v[11], v[12],
			v[13], v[14], v[15], {8{!v[7]}}};
	endfunction
	task automatic acc(input logic w, input logic [15:0] a, v, input k);
		@(posedge mclk_i);
		cs <= 1;
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= v;
		@(posedge mclk_i);
		wr <= 0;
		rd <= 0;
		#1 `CHK("ack", k, ack)
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#20000 err_count++;
		close_out();
	end
	initial begin
		repeat (10) @(posedge mclk_i);
		rstn <= 1;
		#1 `CHK("reset", ex(16'h0), pins)
		repeat (3) @(posedge mclk_i);
		// Write sequences: idle, select, idle
		foreach (tw[i]) begin
			acc(1, 16'h10, tw[i], 1);
			`CHK("pins", ex(tw[i]), pins)
		end
		$display("write test done");
		acc(1, 16'h10, 16'h00c0, 1);
		acc(1, 16'h10, 16'h00fe, 1);
		repeat (4) @(posedge mclk_i);
		acc(0, 16'h10, 16'h0, 1);
		`CHK("rdata", 16'hb8c2, rdata)
		acc(1, 16'h10, 16'h00c0, 1);
		$display("read test done");
		acc(1, 16'h12, 16'hffff, 0);
		me <= 0;
		repeat (3) @(posedge mclk_i);
		acc(1, 16'h10, 16'hffff, 0);
		`CHK("pins", ex(16'h00c0), pins)
		$display("decode test done");
		close_out();
	end
endmodule
